// ===== core/dsc_pkg.sv
/*
 * Constants, field layout and state encoding for the dual synthesizer
 * configuration register bank.
 * Assumes: included by every design file of the block; no clock of its own.
 */
//
// What this block does
// [R1] frames are address then data, MSB first, sixteen bits per frame
// [R2] reset clears all registers except both integer dividers, which hold six
// [R3] main integer index is nine bits, division minus 32, legality by mode
// [R4] main dividend is 18-bit two's complement, high ten plus low eight bits
// [R5] in 10-bit modulator mode the low dividend register is ignored
// [R6] main dividend offsets main integer division by minus to plus one half
// [R7] controller accounts for the fixed divide-by-four prescaler itself
// [R8] auxiliary integer index is nine bits, division minus 32, legal by mode
// [R9] auxiliary dividend is ten bits, fractional offset of plus or minus half
// [R10] reference register bits 4:0 main, bits 9:5 auxiliary, ratios 1 to 32
// [R11] reference index is ratio minus one; zero passes undivided; default zero
// [R12] main detector gain is five bits, codes 0-31 select 31.25 to 1000 uA
// [R13] auxiliary detector gain is five bits, codes 0-31 select 31.25 to 1000 uA
// [R14] main steer flag picks open-collector lock indicator or power steering
// [R15] auxiliary steer flag picks open-collector lock indicator or steering
// [R16] full power-down stops all but oscillator, serial port and mux pin
// [R17] main power-down flag powers main synthesizer down while set
// [R18] main mode flag set gives integer-N, clear gives fractional-N
// [R19] main size flag clear is 18-bit modulator, set is 10-bit
// [R20] auxiliary power-down flag powers auxiliary synthesizer down while set
// [R21] auxiliary mode flag set gives integer-N, clear gives fractional-N
// [R22] frame is four address bits then twelve data bits; addresses 0 to 9
// [R23] registers are write only; nothing is ever read back
// [R24] a register updates only on a complete frame at chip-select release

package dsc_pkg;

  // ------------------------------------------------------------
  // frame layout
  // ------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int ADDR_BITS  = 4;
  localparam int DATA_BITS  = 12;
  localparam int CNT_W      = 5;
  localparam int SYNC_STAGES = 2;

  // ------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------
  localparam int NUM_REGS = 8;
  localparam logic [3:0] ADDR_MAIN_INT  = 4'h0;
  localparam logic [3:0] ADDR_MAIN_HI   = 4'h1;
  localparam logic [3:0] ADDR_MAIN_LO   = 4'h2;
  localparam logic [3:0] ADDR_AUX_INT   = 4'h3;
  localparam logic [3:0] ADDR_AUX_DIV   = 4'h4;
  localparam logic [3:0] ADDR_REF_DIV   = 4'h5;
  localparam logic [3:0] ADDR_GAIN      = 4'h6;
  localparam logic [3:0] ADDR_POWER     = 4'h7;
  localparam logic [3:0] ADDR_LAST      = 4'h9;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [11:0] RST_INT_DIV = 12'h006;
  localparam logic [11:0] RST_ZERO    = 12'h000;

  // ------------------------------------------------------------
  // field layout
  // ------------------------------------------------------------
  localparam int INDEX_W   = 9;
  localparam int DIV_OUT_W = 10;
  localparam logic [9:0] INT_OFFSET   = 10'h020;
  localparam logic [8:0] FRAC_IDX_MIN = 9'h006;
  localparam logic [8:0] FRAC_IDX_MAX = 9'h1F9;
  localparam int HI_W      = 10;
  localparam int LO_W      = 8;
  localparam int AUXD_W    = 10;
  localparam int REF_W     = 5;
  localparam int REF_MAIN_LSB = 0;
  localparam int REF_AUX_LSB  = 5;
  localparam int GAIN_W        = 5;
  localparam int GAIN_MAIN_LSB = 0;
  localparam int STEER_MAIN    = 5;
  localparam int GAIN_AUX_LSB  = 6;
  localparam int STEER_AUX     = 11;
  localparam int PD_FULL   = 0;
  localparam int PD_MAIN   = 1;
  localparam int MODE_MAIN = 2;
  localparam int SIZE_MAIN = 3;
  localparam int PD_AUX    = 4;
  localparam int MODE_AUX  = 5;

  // ------------------------------------------------------------
  // serial receiver states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SHIFT  = 3'b010,
    ST_COMMIT = 3'b100
  } dsc_state_t;

endpackage : dsc_pkg

// ===== core/dsc_config_regs.sv
/*
 * Write-only configuration register bank of a dual fractional-N
 * synthesizer, loaded over a three-wire serial port, with the two
 * reference dividers and the lock/steer pin selection it steers.
 * Assumes: clk is the reference oscillator domain; serial pins are
 * asynchronous; lock and steer status inputs come from logic on clk.
 */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// reference divider: one tick every index+1 cycles
// ------------------------------------------------------------
module dsc_ref_divider
  import dsc_pkg::*;
#(
  parameter int W = REF_W
)
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // control
  input  wire logic         run,
  input  wire logic [W-1:0] index,
  // output
  output var  logic         tick
);

  initial
  begin
    if (W < 1)
      $error("dsc_ref_divider: width must be at least one");
  end

  logic [W-1:0] count;
  wire          wrap = (count >= index);
  wire  [W-1:0] next_count = wrap ? '0 : W'(count + 1'b1);

  // index zero wraps every cycle, so the reference passes undivided
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count <= '0;
      tick  <= 1'b0;
    end
    else if (!run)
    begin
      count <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      count <= next_count;  // [R11]
      tick  <= wrap;        // [R11]
    end
  end

endmodule : dsc_ref_divider

// ------------------------------------------------------------
// top: serial receiver and register bank
// ------------------------------------------------------------
module dsc_config_regs
  import dsc_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // three-wire serial port
  input  wire logic                 ser_clk,
  input  wire logic                 ser_data,
  input  wire logic                 ser_cs_n,
  // loop status from the analog side
  input  wire logic                 main_locked,
  input  wire logic                 main_steer,
  input  wire logic                 aux_locked,
  input  wire logic                 aux_steer,
  // main synthesizer configuration
  output var  logic [DIV_OUT_W-1:0] main_division,
  output var  logic                 main_index_legal,
  output var  logic [HI_W+LO_W-1:0] main_dividend,
  output var  logic                 main_frac_enable,
  output var  logic                 main_mod_10bit,
  output var  logic                 main_enable,
  output var  logic [GAIN_W-1:0]    main_cp_gain,
  // auxiliary synthesizer configuration
  output var  logic [DIV_OUT_W-1:0] aux_division,
  output var  logic                 aux_index_legal,
  output var  logic [AUXD_W-1:0]    aux_dividend,
  output var  logic                 aux_frac_enable,
  output var  logic                 aux_enable,
  output var  logic [GAIN_W-1:0]    aux_cp_gain,
  // divided references
  output var  logic                 ref_main_tick,
  output var  logic                 ref_aux_tick,
  // lock/steer pins, open collector in lock mode
  output var  logic                 main_lock_steer_pin_o,
  output var  logic                 main_lock_steer_pin_oe,
  output var  logic                 aux_lock_steer_pin_o,
  output var  logic                 aux_lock_steer_pin_oe,
  // frame status
  output var  logic                 frame_written,
  output var  logic                 frame_dropped
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [SYNC_STAGES-1:0] clk_sync;
  logic [SYNC_STAGES-1:0] data_sync;
  logic [SYNC_STAGES-1:0] cs_sync;
  logic                   clk_prev;
  logic                   cs_prev;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clk_sync  <= '0;
      data_sync <= '0;
      cs_sync   <= '1;
      clk_prev  <= 1'b0;
      cs_prev   <= 1'b1;
    end
    else
    begin
      clk_sync  <= {clk_sync[SYNC_STAGES-2:0], ser_clk};
      data_sync <= {data_sync[SYNC_STAGES-2:0], ser_data};
      cs_sync   <= {cs_sync[SYNC_STAGES-2:0], ser_cs_n};
      clk_prev  <= clk_sync[SYNC_STAGES-1];
      cs_prev   <= cs_sync[SYNC_STAGES-1];
    end
  end

  wire clk_s    = clk_sync[SYNC_STAGES-1];
  wire data_s   = data_sync[SYNC_STAGES-1];
  wire cs_s     = cs_sync[SYNC_STAGES-1];
  wire clk_rise = clk_s & ~clk_prev;
  wire cs_fall  = ~cs_s & cs_prev;
  wire cs_rise  = cs_s & ~cs_prev;

  // ------------------------------------------------------------
  // frame receiver
  // ------------------------------------------------------------
  dsc_state_t            state;
  dsc_state_t            next_state;
  logic [FRAME_BITS-1:0] shift;
  logic [CNT_W-1:0]      bit_count;

  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FRAME_BITS);
  localparam logic [CNT_W-1:0] CNT_SAT  = CNT_W'(FRAME_BITS + 1);

  // too many bits saturates above a full frame so it is rejected too
  wire [CNT_W-1:0] next_count =
    (bit_count == CNT_SAT) ? bit_count : CNT_W'(bit_count + 1'b1);
  wire frame_ok = (bit_count == CNT_FULL);  // [R1] [R24]

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (cs_fall)
          next_state = ST_SHIFT;
      ST_SHIFT:
        if (cs_rise)
          next_state = frame_ok ? ST_COMMIT : ST_IDLE;  // [R24]
      ST_COMMIT:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state     <= ST_IDLE;
      shift     <= '0;
      bit_count <= '0;
    end
    else
    begin
      state <= next_state;
      if (state == ST_IDLE && cs_fall)
        bit_count <= '0;
      else if (state == ST_SHIFT && clk_rise && !cs_s)
      begin
        shift     <= {shift[FRAME_BITS-2:0], data_s};  // [R1]
        bit_count <= next_count;
      end
    end
  end

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  wire [ADDR_BITS-1:0] frame_addr = shift[FRAME_BITS-1:DATA_BITS];  // [R22]
  wire [DATA_BITS-1:0] frame_data = shift[DATA_BITS-1:0];           // [R22]
  wire                 commit     = (state == ST_COMMIT);
  // modulation registers 8 and 9 are decoded elsewhere, so skipped here
  wire                 in_bank    = (frame_addr < ADDR_BITS'(NUM_REGS));
  wire                 drop_now   = (state == ST_SHIFT) && cs_rise && !frame_ok;

  // ------------------------------------------------------------
  // register bank, write only: no path back to the pins
  // ------------------------------------------------------------
  logic [DATA_BITS-1:0] bank [NUM_REGS];

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        bank[i] <= (i == int'(ADDR_MAIN_INT) || i == int'(ADDR_AUX_INT)) ?
                   RST_INT_DIV : RST_ZERO;  // [R2]
    end
    else if (commit && in_bank)
      bank[frame_addr[2:0]] <= frame_data;  // [R22] [R23] [R24]
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      frame_written <= 1'b0;
      frame_dropped <= 1'b0;
    end
    else
    begin
      frame_written <= commit && (frame_addr <= ADDR_LAST);
      frame_dropped <= drop_now;  // [R24]
    end
  end

  // ------------------------------------------------------------
  // field extraction
  // ------------------------------------------------------------
  wire [DATA_BITS-1:0] r_main_int = bank[ADDR_MAIN_INT[2:0]];
  wire [DATA_BITS-1:0] r_main_hi  = bank[ADDR_MAIN_HI[2:0]];
  wire [DATA_BITS-1:0] r_main_lo  = bank[ADDR_MAIN_LO[2:0]];
  wire [DATA_BITS-1:0] r_aux_int  = bank[ADDR_AUX_INT[2:0]];
  wire [DATA_BITS-1:0] r_aux_div  = bank[ADDR_AUX_DIV[2:0]];
  wire [DATA_BITS-1:0] r_ref      = bank[ADDR_REF_DIV[2:0]];
  wire [DATA_BITS-1:0] r_gain     = bank[ADDR_GAIN[2:0]];
  wire [DATA_BITS-1:0] r_power    = bank[ADDR_POWER[2:0]];

  wire [INDEX_W-1:0] main_idx = r_main_int[INDEX_W-1:0];  // [R3]
  wire [INDEX_W-1:0] aux_idx  = r_aux_int[INDEX_W-1:0];   // [R8]

  wire full_pd    = r_power[PD_FULL];    // [R16]
  wire main_pd    = r_power[PD_MAIN];    // [R17]
  wire main_int_n = r_power[MODE_MAIN];  // [R18]
  wire main_10bit = r_power[SIZE_MAIN];  // [R19]
  wire aux_pd     = r_power[PD_AUX];     // [R20]
  wire aux_int_n  = r_power[MODE_AUX];   // [R21]

  // division = index + 32; the divide-by-four prescaler is the caller's job
  wire [DIV_OUT_W-1:0] next_main_division = DIV_OUT_W'({1'b0, main_idx} + INT_OFFSET);  // [R3] [R7]
  wire [DIV_OUT_W-1:0] next_aux_division  = DIV_OUT_W'({1'b0, aux_idx} + INT_OFFSET);   // [R8]

  // index range only narrows in fractional-N mode
  wire next_main_legal = main_int_n ||
                         (main_idx >= FRAC_IDX_MIN && main_idx <= FRAC_IDX_MAX);  // [R3]
  wire next_aux_legal  = aux_int_n ||
                         (aux_idx >= FRAC_IDX_MIN && aux_idx <= FRAC_IDX_MAX);    // [R8]

  // low byte ignored in 10-bit mode, so a stale value there is harmless
  wire [LO_W-1:0] main_lo_used = main_10bit ? LO_W'(0) : r_main_lo[LO_W-1:0];  // [R5] [R19]
  wire [HI_W+LO_W-1:0] next_main_dividend = {r_main_hi[HI_W-1:0], main_lo_used};  // [R4] [R6]

  wire next_main_enable = !full_pd && !main_pd;  // [R16] [R17]
  wire next_aux_enable  = !full_pd && !aux_pd;   // [R16] [R20]

  // ------------------------------------------------------------
  // lock/steer pin selection
  // ------------------------------------------------------------
  // lock mode pulls low only when locked; steer mode drives actively
  wire main_steer_mode = r_gain[STEER_MAIN];  // [R14]
  wire aux_steer_mode  = r_gain[STEER_AUX];   // [R15]

  wire next_main_pin_o  = main_steer_mode ? main_steer : 1'b0;              // [R14]
  wire next_main_pin_oe = next_main_enable && (main_steer_mode || main_locked);  // [R14]
  wire next_aux_pin_o   = aux_steer_mode ? aux_steer : 1'b0;                // [R15]
  wire next_aux_pin_oe  = next_aux_enable && (aux_steer_mode || aux_locked);     // [R15]

  // ------------------------------------------------------------
  // registered configuration outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      main_division    <= '0;
      main_index_legal <= 1'b0;
      main_dividend    <= '0;
      main_frac_enable <= 1'b0;
      main_mod_10bit   <= 1'b0;
      main_enable      <= 1'b0;
      main_cp_gain     <= '0;
    end
    else
    begin
      main_division    <= next_main_division;                        // [R3]
      main_index_legal <= next_main_legal;                           // [R3]
      main_dividend    <= next_main_dividend;                        // [R4] [R6]
      main_frac_enable <= !main_int_n && next_main_enable;           // [R18]
      main_mod_10bit   <= main_10bit;                                // [R19]
      main_enable      <= next_main_enable;                          // [R17]
      main_cp_gain     <= r_gain[GAIN_MAIN_LSB +: GAIN_W];           // [R12]
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aux_division    <= '0;
      aux_index_legal <= 1'b0;
      aux_dividend    <= '0;
      aux_frac_enable <= 1'b0;
      aux_enable      <= 1'b0;
      aux_cp_gain     <= '0;
    end
    else
    begin
      aux_division    <= next_aux_division;                // [R8]
      aux_index_legal <= next_aux_legal;                   // [R8]
      aux_dividend    <= r_aux_div[AUXD_W-1:0];            // [R9]
      aux_frac_enable <= !aux_int_n && next_aux_enable;    // [R21]
      aux_enable      <= next_aux_enable;                  // [R20]
      aux_cp_gain     <= r_gain[GAIN_AUX_LSB +: GAIN_W];   // [R13]
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      main_lock_steer_pin_o  <= 1'b0;
      main_lock_steer_pin_oe <= 1'b0;
      aux_lock_steer_pin_o   <= 1'b0;
      aux_lock_steer_pin_oe  <= 1'b0;
    end
    else
    begin
      main_lock_steer_pin_o  <= next_main_pin_o;   // [R14]
      main_lock_steer_pin_oe <= next_main_pin_oe;  // [R14]
      aux_lock_steer_pin_o   <= next_aux_pin_o;    // [R15]
      aux_lock_steer_pin_oe  <= next_aux_pin_oe;   // [R15]
    end
  end

  // ------------------------------------------------------------
  // reference dividers, stopped while their synthesizer is down
  // ------------------------------------------------------------
  dsc_ref_divider #(
    .W       (REF_W)
  ) u_ref_main (
    .clk     (clk),
    .reset_n (reset_n),
    .run     (next_main_enable),
    .index   (r_ref[REF_MAIN_LSB +: REF_W]),  // [R10]
    .tick    (ref_main_tick)
  );

  dsc_ref_divider #(
    .W       (REF_W)
  ) u_ref_aux (
    .clk     (clk),
    .reset_n (reset_n),
    .run     (next_aux_enable),
    .index   (r_ref[REF_AUX_LSB +: REF_W]),   // [R10]
    .tick    (ref_aux_tick)
  );

endmodule : dsc_config_regs

`default_nettype wire

// ===== core/dsc_config_regs_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== test/dsc_config_regs_assertions.sv
/*
 * Checker for the configuration register bank, bound to its top.
 * Assumes: sees top ports only; clk domain, reset_n async active low.
 */
`timescale 1ns/1ps
`default_nettype none

module dsc_config_regs_assertions
  import dsc_pkg::*;
(
  // clock and reset
  input wire logic                 clk,
  input wire logic                 reset_n,
  // loop status
  input wire logic                 main_steer,
  input wire logic                 aux_steer,
  // configuration
  input wire logic [DIV_OUT_W-1:0] main_division,
  input wire logic                 main_index_legal,
  input wire logic [HI_W+LO_W-1:0] main_dividend,
  input wire logic                 main_frac_enable,
  input wire logic                 main_mod_10bit,
  input wire logic                 main_enable,
  input wire logic [DIV_OUT_W-1:0] aux_division,
  input wire logic                 aux_index_legal,
  input wire logic                 aux_frac_enable,
  input wire logic                 aux_enable,
  // pins and status
  input wire logic                 main_lock_steer_pin_o,
  input wire logic                 main_lock_steer_pin_oe,
  input wire logic                 aux_lock_steer_pin_o,
  input wire logic                 aux_lock_steer_pin_oe,
  input wire logic                 frame_written,
  input wire logic                 frame_dropped
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_main_div;
    main_enable |-> main_division inside {[10'h020:10'h21F]};
  endproperty
  a_main_div: assert property (p_main_div)
    else $error("main division out of range");
  property p_aux_div;
    aux_enable |-> aux_division inside {[10'h020:10'h21F]};
  endproperty
  a_aux_div: assert property (p_aux_div)
    else $error("aux division out of range");
  property p_main_legal;
    main_frac_enable |-> main_index_legal == (main_division inside {[10'h026:10'h219]});
  endproperty
  a_main_legal: assert property (p_main_legal)
    else $error("main legality wrong in fractional mode");
  property p_main_int_legal;
    main_enable && !main_frac_enable |-> main_index_legal;
  endproperty
  a_main_int_legal: assert property (p_main_int_legal)
    else $error("main index refused in integer mode");
  property p_aux_legal;
    aux_frac_enable |-> aux_index_legal == (aux_division inside {[10'h026:10'h219]});
  endproperty
  a_aux_legal: assert property (p_aux_legal)
    else $error("aux legality wrong in fractional mode");
  property p_frac_en;
    (main_frac_enable -> main_enable) && (aux_frac_enable -> aux_enable);
  endproperty
  a_frac_en: assert property (p_frac_en)
    else $error("fractional unit on while synthesizer off");
  property p_lo_forced;
    main_mod_10bit |-> main_dividend[7:0] == 8'h00;
  endproperty
  a_lo_forced: assert property (p_lo_forced)
    else $error("low dividend used in 10-bit mode");
  property p_main_steer;
    main_lock_steer_pin_oe && main_lock_steer_pin_o |-> $past(main_steer);
  endproperty
  a_main_steer: assert property (p_main_steer)
    else $error("main pin driven high without steering");
  property p_aux_steer;
    aux_lock_steer_pin_oe && aux_lock_steer_pin_o |-> $past(aux_steer);
  endproperty
  a_aux_steer: assert property (p_aux_steer)
    else $error("aux pin driven high without steering");
  property p_write_pulse;
    frame_written |=> !frame_written && !frame_dropped;
  endproperty
  a_write_pulse: assert property (p_write_pulse)
    else $error("write status not a single pulse");
  property p_drop_keeps;
    frame_dropped |-> ##1 $stable(main_division) [*3];
  endproperty
  a_drop_keeps: assert property (p_drop_keeps)
    else $error("dropped frame changed a register");
endmodule : dsc_config_regs_assertions

bind dsc_config_regs dsc_config_regs_assertions u_chk (.*);

`default_nettype wire

// ===== test/dsc_ser_master.sv
/*
 * Controller model driving the three-wire serial port.
 * Assumes: free running in its own time, unrelated to clk.
 */
`timescale 1ns/1ps
`default_nettype none

module dsc_ser_master (
  // three-wire serial port
  output var logic ser_clk,
  output var logic ser_data,
  output var logic ser_cs_n
);
  initial
  begin
    ser_clk  = 1'b0;
    ser_data = 1'b0;
    ser_cs_n = 1'b1;
  end

  // n other than 16 only for refused frames
  task automatic send(input logic [16:0] v, input int n);
    ser_cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      ser_data = v[i];
      #62.5 ser_clk = 1'b1;
      #62.5 ser_clk = 1'b0;
    end
    #40 ser_cs_n = 1'b1;
    // released line: no stale bit left for the receiver to trust
    ser_data = ~ser_data;
    #100;
  endtask : send
endmodule : dsc_ser_master

`default_nettype wire

// ===== test/dsc_config_regs_tb.sv
/*
 * Self-checking bench for the configuration register bank.
 * Assumes: serial traffic from dsc_ser_master; checker bound separately.
 */
`timescale 1ns/1ps
`default_nettype none

module dsc_config_regs_tb;
  import dsc_pkg::*;
  typedef struct packed {logic [15:0] f; logic [2:0] s; logic [17:0] e;} dsc_row_t;
  logic clk = 1'b0, reset_n = 1'b0;
  logic main_locked = 1'b1, main_steer = 1'b0, aux_locked = 1'b1, aux_steer = 1'b0;
  wire ser_clk, ser_data, ser_cs_n;
  logic [9:0] main_division, aux_division, aux_dividend;
  logic [17:0] main_dividend;
  logic [4:0] main_cp_gain, aux_cp_gain;
  logic main_index_legal, main_frac_enable, main_mod_10bit, main_enable, aux_index_legal;
  logic aux_frac_enable, aux_enable, ref_main_tick, ref_aux_tick, frame_written;
  logic frame_dropped, mp_o, mp_oe, ap_o, ap_oe;
  int n_mismatch = 0, samples_checked = 0, n_wr = 0, n_drop = 0, n_mt = 0, n_at = 0;
  dsc_row_t rows [19] = '{
    '{16'h002A, 3'h0, 18'h0004A},
    '{16'h1305, 3'h1, 18'h30500},
    '{16'h20CC, 3'h1, 18'h305CC},
    '{16'h3012, 3'h2, 18'h00032},
    '{16'h43BA, 3'h3, 18'h003BA},
    '{16'h67C5, 3'h4, 18'h00005},
    '{16'h67C5, 3'h5, 18'h0001F},
    '{16'h7008, 3'h1, 18'h30500},
    '{16'h7008, 3'h6, 18'h0001F},
    '{16'h7024, 3'h6, 18'h00012},
    '{16'h7012, 3'h6, 18'h00000},
    '{16'h7001, 3'h6, 18'h00000},
    '{16'h7000, 3'h6, 18'h0001B},
    '{16'h01FA, 3'h7, 18'h00001},
    '{16'h0005, 3'h7, 18'h00001},
    '{16'h01F9, 3'h7, 18'h00003},
    '{16'h31FA, 3'h7, 18'h00002},
    '{16'h7024, 3'h7, 18'h00003},
    '{16'h01FF, 3'h0, 18'h0021F}};

  dsc_ser_master host (.ser_clk(ser_clk), .ser_data(ser_data), .ser_cs_n(ser_cs_n));
  dsc_config_regs DUT (
    .clk(clk), .reset_n(reset_n), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_cs_n(ser_cs_n), .main_locked(main_locked), .main_steer(main_steer),
    .aux_locked(aux_locked), .aux_steer(aux_steer), .main_division(main_division),
    .main_index_legal(main_index_legal), .main_dividend(main_dividend),
    .main_frac_enable(main_frac_enable), .main_mod_10bit(main_mod_10bit),
    .main_enable(main_enable), .main_cp_gain(main_cp_gain),
    .aux_division(aux_division), .aux_index_legal(aux_index_legal),
    .aux_dividend(aux_dividend), .aux_frac_enable(aux_frac_enable),
    .aux_enable(aux_enable), .aux_cp_gain(aux_cp_gain),
    .ref_main_tick(ref_main_tick), .ref_aux_tick(ref_aux_tick),
    .main_lock_steer_pin_o(mp_o), .main_lock_steer_pin_oe(mp_oe),
    .aux_lock_steer_pin_o(ap_o), .aux_lock_steer_pin_oe(ap_oe),
    .frame_written(frame_written), .frame_dropped(frame_dropped));

  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    n_wr   += (frame_written === 1'b1);
    n_drop += (frame_dropped === 1'b1);
    n_mt   += (ref_main_tick === 1'b1);
    n_at   += (ref_aux_tick === 1'b1);
  end

  task chk(input logic [17:0] got, input logic [17:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function logic [17:0] pick(input logic [2:0] s);
    case (s)
      3'h0: return {8'h00, main_division};
      3'h1: return main_dividend;
      3'h2: return {8'h00, aux_division};
      3'h3: return {8'h00, aux_dividend};
      3'h4: return {13'h0000, main_cp_gain};
      3'h5: return {13'h0000, aux_cp_gain};
      3'h6: return {13'h0000, main_enable, main_frac_enable, main_mod_10bit,
                    aux_enable, aux_frac_enable};
      default: return {16'h0000, main_index_legal, aux_index_legal};
    endcase
  endfunction : pick

  task cnt(input int n);
    n_mt = 0;
    n_at = 0;
    repeat (n) @(posedge clk);
    #1;
  endtask : cnt

  task end_of_test;
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  initial
  begin
    #400000;
    n_mismatch++;
    end_of_test;
  end

  initial
  begin
    int w;
    repeat (8) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge clk);
    foreach (rows[i])
    begin
      host.send({1'b0, rows[i].f}, 16);
      chk(pick(rows[i].s), rows[i].e);
    end
    // ------------------------------------------------------------
    // second reset and reference dividers
    // ------------------------------------------------------------
    @(posedge clk);
    #1 reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk(pick(0), 18'h00026);
    chk(pick(2), 18'h00026);
    chk(pick(1) | pick(3), 18'h00000);
    chk(pick(6), 18'h0001B);
    cnt(20);
    chk({n_mt[8:0], n_at[8:0]}, {9'h014, 9'h014});
    host.send(17'h053E3, 16);
    cnt(64);
    chk({n_mt[8:0], n_at[8:0]}, {9'h010, 9'h002});
    // ------------------------------------------------------------
    // refused frames and unmapped addresses
    // ------------------------------------------------------------
    host.send(17'h000FF, 15);
    host.send(17'h000FF, 17);
    chk(18'(n_drop), 18'h00002);
    chk(pick(0), 18'h00026);
    w = n_wr;
    host.send(17'h08123, 16);
    host.send(17'h0A0FF, 16);
    chk(18'(n_wr - w), 18'h00001);
    chk(pick(0) | pick(1), 18'h00026);
    // ------------------------------------------------------------
    // lock and steering pins
    // ------------------------------------------------------------
    chk({14'h0000, mp_o, mp_oe, ap_o, ap_oe}, 18'h00005);
    @(posedge clk);
    #1 main_steer = 1'b1;
    aux_steer = 1'b1;
    main_locked = 1'b0;
    @(posedge clk);
    #1 chk({14'h0000, mp_o, mp_oe, ap_o, ap_oe}, 18'h00001);
    host.send(17'h06820, 16);
    chk({14'h0000, mp_o, mp_oe, ap_o, ap_oe}, 18'h0000F);
    host.send(17'h07012, 16);
    chk({16'h0000, mp_oe, ap_oe}, 18'h00000);
    end_of_test;
  end
endmodule : dsc_config_regs_tb

`default_nettype wire
